// ==== dv/pll_link_properties.sv ====
/*
  Checker for the serial link, latch loads, lock detect and monitor pin.
  Assumes one clk domain with synchronous rst; every input is a plain
  copy of an interface signal or a device port.
*/
`timescale 1ns/1ps
module pll_link_properties (
  input wire logic                            clk,
  input wire logic                            rst,
  input wire logic                            sclk,
  input wire logic                            sdata,
  input wire logic                            loadStrobe,
  input wire logic                            monitorLevel,
  input wire logic                            pdCycle,
  input wire logic [pll_ctl_pkg::ERR_W-1:0]   phaseErrNs,
  input wire logic                            pumpActive,
  input wire logic [pll_ctl_pkg::LATCH_W-1:0] refLatch,
  input wire logic [pll_ctl_pkg::LATCH_W-1:0] fbLatch,
  input wire logic [pll_ctl_pkg::LATCH_W-1:0] fnLatch,
  input wire logic                            lockDetect
);
  import pll_ctl_pkg::*;
  // ****************************************
  // Helper logic
  // ****************************************
  logic        sclkQ;
  logic [23:0] word;
  logic [2:0]  goodRun;
  logic [7:0]  thr;
  assign thr = fbLatch[LOCK_PREC_BIT] ? LOCK_FINE_NS : LOCK_WIDE_NS;
  always_ff @(posedge clk) begin
    sclkQ <= rst ? 1'b0 : sclk;
  end
  // Mirror of the shift register, fed at each sampled sclk rise
  always_ff @(posedge clk) begin
    if (rst) begin
      word <= '0;
    end else if (sclk && !sclkQ) begin
      word <= {word[22:0], sdata};
    end
  end
  // Saturates so a long good run never wraps back under five
  always_ff @(posedge clk) begin
    if (rst) begin
      goodRun <= 3'h0;
    end else if (pdCycle) begin
      goodRun <= (phaseErrNs >= thr) ? 3'h0 : (goodRun == 3'h7) ? goodRun : goodRun + 3'h1;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_load;
    $rose(loadStrobe);
  endsequence
  property p_strobe_len;
    s_load |-> loadStrobe[*4] ##1 !loadStrobe;
  endproperty
  property p_sdata_hold;
    (sclk && $past(sclk)) |-> $stable(sdata);
  endproperty
  property p_ref_load;
    s_load ##0 (word[1:0] == SEL_REF) |-> ##[1:8] (refLatch == word);
  endproperty
  property p_fb_load;
    s_load ##0 (word[1:0] == SEL_FB) |-> ##[1:8] (fbLatch == word);
  endproperty
  property p_fn_load;
    s_load ##0 (word[1:0] == SEL_FN) |-> ##[1:8] (fnLatch == word);
  endproperty
  property p_no_load;
    s_load ##0 (word[1:0] == 2'h3) |=> ($stable(refLatch) && $stable(fbLatch)
      && $stable(fnLatch))[*8];
  endproperty
  property p_lock_rise;
    $rose(lockDetect) |-> (goodRun >= LOCK_CYCLES);
  endproperty
  property p_lock_fall;
    (pdCycle && phaseErrNs > UNLOCK_NS) |=> !lockDetect;
  endproperty
  property p_mon_analog;
    (fnLatch[6:4] == MON_ANA_LOCK && !pumpActive)[*2] |-> monitorLevel;
  endproperty
  property p_mon_low;
    (fnLatch[6:4] == MON_LOW)[*2] |-> !monitorLevel;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe width wrong");
  a_sdata_hold: assert property (p_sdata_hold) else $error("sdata moved in sclk high");
  a_ref_load: assert property (p_ref_load) else $error("reference latch not loaded");
  a_fb_load: assert property (p_fb_load) else $error("counter latch not loaded");
  a_fn_load: assert property (p_fn_load) else $error("function latch not loaded");
  a_no_load: assert property (p_no_load) else $error("latch changed on select 11");
  a_lock_rise: assert property (p_lock_rise) else $error("lock rose too early");
  a_lock_fall: assert property (p_lock_fall) else $error("lock held after big error");
  a_mon_analog: assert property (p_mon_analog) else $error("analog monitor low idle");
  a_mon_low: assert property (p_mon_low) else $error("monitor not low");
endmodule

// ==== dv/pll_serial_latch_lock_detect_test.sv ====
/*
  Testbench: host and device joined by the link interface, registers
  driven through the host port. Assumes 40 MHz clk and default divider.
*/
`timescale 1ns/1ps
module pll_serial_latch_lock_detect_test;
  import pll_ctl_pkg::*;
  typedef struct {string name; logic [31:0] exp; int kind;} note_s;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        clkEn = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  logic        chipEnable = 1'b1;
  logic        pdCycle = 1'b0;
  logic [7:0]  phaseErrNs = 8'h00;
  logic        pumpActive = 1'b0;
  logic        refDivOut = 1'b0;
  logic        fbDivOut = 1'b1;
  logic [23:0] refLatch, fbLatch, fnLatch, w, refW, fbW;
  logic        counterReset, powerDown, lockDetect;
  logic        rdPend = 1'b0;
  logic        probe = 1'b0;
  logic [31:0] seen;
  logic [7:0]  monExp = 8'h2d;
  note_s       notes[$];
  note_s       n;
  int          err_total = 0;
  int          total_checks = 0;
  always #12.5 clk = ~clk;
  serial_link_if link();
  pll_serial_host u_pll_serial_host (.clk(clk), .rst(rst), .clkEn(clkEn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .link(link));
  pll_serial_device u_pll_serial_device (.clk(clk), .rst(rst), .clkEn(clkEn),
    .chipEnable(chipEnable), .pdCycle(pdCycle), .phaseErrNs(phaseErrNs),
    .pumpActive(pumpActive), .refDivOut(refDivOut), .fbDivOut(fbDivOut),
    .refLatch(refLatch), .fbLatch(fbLatch), .fnLatch(fnLatch), .counterReset(counterReset),
    .powerDown(powerDown), .lockDetect(lockDetect), .link(link));
  pll_link_properties u_pll_link_properties (.clk(clk), .rst(rst), .sclk(link.sclk),
    .sdata(link.sdata), .loadStrobe(link.loadStrobe), .monitorLevel(link.monitorLevel),
    .pdCycle(pdCycle), .phaseErrNs(phaseErrNs), .pumpActive(pumpActive),
    .refLatch(refLatch), .fbLatch(fbLatch), .fnLatch(fnLatch), .lockDetect(lockDetect));
  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge clk) begin
    rdPend <= rd;
    if (rdPend || probe) begin
      n = notes.pop_front();
      case (n.kind)
        0: seen = rdata;
        1: seen = {8'h0, refLatch};
        2: seen = {8'h0, fbLatch};
        3: seen = {8'h0, fnLatch};
        4: seen = {31'h0, lockDetect};
        5: seen = {31'h0, link.monitorLevel};
        7: seen = {30'h0, powerDown, counterReset};
        default: seen = {31'h0, irq};
      endcase
      total_checks++;
      if (seen !== n.exp) begin
        err_total++;
        $display("CHECK FAILED %s expected %h seen %h", n.name, n.exp, seen);
      end
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string s);
    notes.push_back('{s, e, 0});
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic peek(input int k, input logic [31:0] e, input string s);
    notes.push_back('{s, e, k});
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    @(posedge clk);
  endtask
  // Fixed wait: 24 bits of 8 cycles, strobe, sync margin
  task automatic send(input logic [23:0] d);
    wr_reg(OFF_WORD, {8'h0, d});
    repeat (24 * 8 + 16) @(posedge clk);
  endtask
  task automatic pd(input logic [7:0] e);
    pdCycle <= 1'b1;
    phaseErrNs <= e;
    @(posedge clk);
    pdCycle <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end
  initial begin
    void'($urandom(73));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(OFF_IRQ_MASK, 32'h0, "irqMask");
    rd_chk(8'h10, 32'h0, "unmapped");
    rd_chk(OFF_STATUS, 32'h2, "status");
    wr_reg(OFF_IRQ_STATUS, 32'h7);
    refW = {6'h0, BACKLASH_REQ, 14'($urandom_range(16383, 1)), SEL_REF};
    send(refW);
    peek(1, {8'h0, refW}, "refLatch");
    peek(6, 32'h0, "irqMasked");
    rd_chk(OFF_IRQ_STATUS, 32'h1, "irqStatus");
    rd_chk(OFF_WORD, {8'h0, refW}, "lastWord");
    wr_reg(OFF_IRQ_MASK, 32'h1);
    peek(6, 32'h1, "irqRaised");
    wr_reg(OFF_IRQ_STATUS, 32'h1);
    peek(6, 32'h0, "irqCleared");
    $display("test registers done");
    fbW = {3'h0, 13'($urandom_range(8191, 3)), 6'($urandom), SEL_FB};
    send(fbW);
    peek(2, {8'h0, fbW}, "fbLatch");
    peek(1, {8'h0, refW}, "refKept");
    for (int c = 0; c < 8; c++) begin
      w = {17'h0, 3'(c), 2'h0, SEL_FN};
      send(w);
      peek(3, {8'h0, w}, "fnLatch");
      peek(5, {31'h0, monExp[c]}, "monitor");
      if (c == 5) begin
        pumpActive <= 1'b1;
        repeat (3) @(posedge clk);
        peek(5, 32'h0, "monPulse");
        pumpActive <= 1'b0;
        repeat (3) @(posedge clk);
        peek(5, 32'h1, "monRest");
      end
    end
    rd_chk(OFF_IRQ_STATUS, 32'h7, "irqMonitor");
    send({22'($urandom), 2'h3});
    peek(1, {8'h0, refW}, "refNoLoad");
    peek(2, {8'h0, fbW}, "fbNoLoad");
    peek(3, {8'h0, w}, "fnNoLoad");
    $display("test latches done");
    repeat (4) pd(8'h09);
    peek(4, 32'h0, "lockFour");
    pd(8'h09);
    peek(4, 32'h1, "lockFive");
    pd(8'h14);
    pd(8'h19);
    peek(4, 32'h1, "lockHeld");
    pd(8'h1a);
    peek(4, 32'h0, "lockLost");
    send(fbW | 24'h400000);
    repeat (5) pd(8'h05);
    peek(4, 32'h0, "fineCoarse");
    repeat (5) pd(8'h02);
    peek(4, 32'h1, "fineLock");
    send(24'h00000a);
    peek(4, 32'h0, "softDownLock");
    peek(7, 32'h3, "softDown");
    send(24'h000006);
    peek(7, 32'h1, "counterClear");
    repeat (5) pd(8'h02);
    peek(4, 32'h1, "relock");
    chipEnable <= 1'b0;
    repeat (8) @(posedge clk);
    peek(4, 32'h0, "powerDownLock");
    peek(7, 32'h3, "ceDown");
    chipEnable <= 1'b1;
    $display("test lock detect done");
    stop_test();
  end
endmodule

// ==== src/pin_sync.sv ====
/*
  Three-flop synchroniser with agreement filter and rise detect.
  Assumes asynchronous inputs; the first flop feeds only the second.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH      = 1,
  parameter logic [WIDTH-1:0] IDLE_LEVEL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  initial begin
    if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
  end

  // A change counts only once stages two and three agree
  assign next_level = (stage2 & stage3) | (level & (stage2 | stage3));

  always_ff @(posedge clk) begin
    if (rst) begin
      // Starting at the idle level keeps a false edge out of reset
      stage1 <= IDLE_LEVEL;
      stage2 <= IDLE_LEVEL;
      stage3 <= IDLE_LEVEL;
      level  <= IDLE_LEVEL;
      rise   <= '0;
    end else if (clkEn) begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
      rise   <= next_level & ~level;
    end
  end
endmodule

// ==== src/pll_ctl_pkg.sv ====
/*
  Shared constants for the synthesizer control section: latch layout,
  select codes, lock thresholds, monitor modes and host register map.
  Assumes a 40 MHz system clock on both ends.
*/
package pll_ctl_pkg;
  // ****************************************
  // Latch layout
  // ****************************************
  localparam int          LATCH_W        = 24;
  localparam logic [1:0]  SEL_REF        = 2'h0;
  localparam logic [1:0]  SEL_FB         = 2'h1;
  localparam logic [1:0]  SEL_FN         = 2'h2;
  localparam int          SEL_LSB        = 0;
  localparam int          REF_DIV_LSB    = 2;
  localparam int          REF_DIV_MSB    = 15;
  localparam int          BACKLASH_LSB   = 16;
  localparam int          BACKLASH_MSB   = 17;
  localparam logic [1:0]  BACKLASH_REQ   = 2'h2;
  localparam int          SWALLOW_LSB    = 2;
  localparam int          SWALLOW_MSB    = 7;
  localparam int          MAIN_DIV_LSB   = 8;
  localparam int          MAIN_DIV_MSB   = 20;
  localparam int          LOCK_PREC_BIT  = 22;
  localparam int          COUNTER_CLEAR_BIT = 2;
  localparam int          POWERDOWN_BIT  = 3;
  localparam int          MON_SEL_LSB    = 4;
  localparam int          MON_SEL_MSB    = 6;
  localparam logic [23:0] LATCH_RESET    = 24'h000000;
  localparam logic [23:0] REF_KEEP_MASK  = 24'h03ffff;
  localparam logic [23:0] FB_KEEP_MASK   = 24'h5fffff;
  // ****************************************
  // Lock detection
  // ****************************************
  localparam int          ERR_W          = 8;
  localparam logic [7:0]  LOCK_WIDE_NS   = 8'h0a;
  localparam logic [7:0]  LOCK_FINE_NS   = 8'h03;
  localparam logic [7:0]  UNLOCK_NS      = 8'h19;
  localparam logic [2:0]  LOCK_CYCLES    = 3'h5;
  // Monitor select codes
  localparam logic [2:0]  MON_OFF        = 3'h0;
  localparam logic [2:0]  MON_DIG_LOCK   = 3'h1;
  localparam logic [2:0]  MON_FB_DIV     = 3'h2;
  localparam logic [2:0]  MON_HIGH       = 3'h3;
  localparam logic [2:0]  MON_REF_DIV    = 3'h4;
  localparam logic [2:0]  MON_ANA_LOCK   = 3'h5;
  localparam logic [2:0]  MON_SDATA      = 3'h6;
  localparam logic [2:0]  MON_LOW        = 3'h7;
  // ****************************************
  // Host timing and register map
  // ****************************************
  localparam int          CLK_MHZ        = 40;
  localparam int          SCLK_HALF_NS   = 100;
  localparam int          SCLK_HALF_CYC  = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  OFF_WORD       = 8'h00;
  localparam logic [7:0]  OFF_STATUS     = 8'h04;
  localparam logic [7:0]  OFF_IRQ_STATUS = 8'h08;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h0c;
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_DONE       = 0;
  localparam int          IRQ_MON_RISE   = 1;
  localparam int          IRQ_MON_FALL   = 2;
endpackage

// ==== src/pll_serial_device.sv ====
/*
  Digital control section of an integer-N synthesizer: 24-bit serial
  input register, three latches, power-down and counter reset, digital
  and analog lock detect and the monitor pin selector.
  Assumes phase detector strobes and divider outputs come from logic on
  clk; the link pins and chip enable are asynchronous.
*/
// Functional notes
// R1 - Host sets backlash width bits to 10
// R2 - Monitor pin follows three monitor select bits
// R3 - Coarse precision: five cycles under 10 ns
// R4 - Fine precision: five cycles under 3 ns
// R5 - Lock drops on any error over 25 ns
// R6 - Analog lock: open drain, brief low pulses
// R7 - MSB first, one bit per sclk rise
// R8 - Load strobe rise copies word into latch
// R9 - Latch select is word bits one, zero
// R10 - 00 reference, 01 counters, 10 function
// R11 - Reference divide in bits 15..2
// R12 - Swallow, main divide, precision bit positions
// R13 - Unaddressed latches keep their contents
// R14 - Counter clear bit holds counters reset
// R15 - Soft powerdown or chip enable low
`timescale 1ns/1ps
module pll_serial_device (
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire logic                                clkEn,
  input  wire logic                                chipEnable,
  input  wire logic                                pdCycle,
  input  wire logic [pll_ctl_pkg::ERR_W-1:0]       phaseErrNs,
  input  wire logic                                pumpActive,
  input  wire logic                                refDivOut,
  input  wire logic                                fbDivOut,
  output logic      [pll_ctl_pkg::LATCH_W-1:0]     refLatch,
  output logic      [pll_ctl_pkg::LATCH_W-1:0]     fbLatch,
  output logic      [pll_ctl_pkg::LATCH_W-1:0]     fnLatch,
  output logic                                     counterReset,
  output logic                                     powerDown,
  output logic                                     lockDetect,
  serial_link_if.device                            link
);
  import pll_ctl_pkg::*;

  typedef enum logic [1:0] {
    L_HUNT   = 2'b01,
    L_LOCKED = 2'b10
  } lock_state_e;

  logic [3:0]         pinLevel;
  logic [3:0]         pinRise;
  logic               sclkRise;
  logic               sdataLevel;
  logic               loadRise;
  logic               ceLevel;
  logic [LATCH_W-1:0] shiftReg;
  logic               next_powerDown;
  logic               next_counterReset;
  lock_state_e        lockState;
  logic [2:0]         goodCycles;
  logic [ERR_W-1:0]   lockLimit;
  logic [2:0]         monSel;

  // Strict compare used for both lock entry thresholds
  function automatic logic below(input logic [ERR_W-1:0] err, input logic [ERR_W-1:0] lim);
    return err < lim;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  pin_sync #(.WIDTH(4)) pinSync (
    .clk   (clk),
    .rst   (rst),
    .clkEn (clkEn),
    .pinIn ({chipEnable, link.loadStrobe, link.sdata, link.sclk}),
    .level (pinLevel),
    .rise  (pinRise)
  );

  // Data travels the same three flops as its clock, so it is aligned with the edge
  assign sclkRise   = pinRise[0];
  assign sdataLevel = pinLevel[1];
  assign loadRise   = pinRise[2];
  assign ceLevel    = pinLevel[3];

  // ****************************************
  // Input shift register
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      shiftReg <= LATCH_RESET;
    end else if (clkEn && sclkRise) begin
      shiftReg <= {shiftReg[LATCH_W-2:0], sdataLevel}; // R7
    end
  end

  // ****************************************
  // Latches
  // ****************************************
  // Select code 11 addresses nothing and is dropped without effect
  always_ff @(posedge clk) begin
    if (rst) begin
      refLatch <= LATCH_RESET;
      fbLatch  <= LATCH_RESET;
      fnLatch  <= LATCH_RESET;
    end else if (clkEn && loadRise) begin // R8
      if (shiftReg[SEL_LSB+1:SEL_LSB] == SEL_REF) refLatch <= shiftReg; // R9 R10 R11 R13
      else if (shiftReg[SEL_LSB+1:SEL_LSB] == SEL_FB) fbLatch <= shiftReg; // R9 R10 R12 R13
      else if (shiftReg[SEL_LSB+1:SEL_LSB] == SEL_FN) fnLatch <= shiftReg; // R9 R10 R13
    end
  end

  // ****************************************
  // Power-down and counter reset
  // ****************************************
  // Counter clear is only a level here; the counters sit outside
  assign next_powerDown    = fnLatch[POWERDOWN_BIT] | ~ceLevel; // R15
  assign next_counterReset = fnLatch[COUNTER_CLEAR_BIT] | next_powerDown; // R14 R15

  always_ff @(posedge clk) begin
    if (rst) begin
      powerDown    <= 1'b1;
      counterReset <= 1'b1;
    end else if (clkEn) begin
      powerDown    <= next_powerDown;
      counterReset <= next_counterReset;
    end
  end

  // ****************************************
  // Digital lock detect
  // ****************************************
  // Precision bit lives in the counter latch
  assign lockLimit = fbLatch[LOCK_PREC_BIT] ? LOCK_FINE_NS : LOCK_WIDE_NS; // R3 R4

  always_ff @(posedge clk) begin
    if (rst) begin
      lockState  <= L_HUNT;
      goodCycles <= 3'h0;
      lockDetect <= 1'b0;
    end else if (clkEn) begin
      // Power-down clears lock detect at once, not at the next strobe
      if (next_powerDown) begin // R15
        lockState  <= L_HUNT;
        goodCycles <= 3'h0;
        lockDetect <= 1'b0;
      end else if (pdCycle) begin
        case (lockState)
          L_HUNT: begin
            if (!below(phaseErrNs, lockLimit)) begin
              goodCycles <= 3'h0;
            end else if (goodCycles == LOCK_CYCLES - 3'h1) begin // R3 R4
              goodCycles <= 3'h0;
              lockState  <= L_LOCKED;
              lockDetect <= 1'b1;
            end else begin
              goodCycles <= goodCycles + 3'h1;
            end
          end
          L_LOCKED: begin
            if (phaseErrNs > UNLOCK_NS) begin // R5
              lockState  <= L_HUNT;
              lockDetect <= 1'b0;
            end
          end
          default: lockState <= L_HUNT;
        endcase
      end
    end
  end

  // ****************************************
  // Monitor pin
  // ****************************************
  assign monSel = fnLatch[MON_SEL_MSB:MON_SEL_LSB]; // R2

  // Push-pull sources drive with the enable low; off and analog modes release the pin
  always_ff @(posedge clk) begin
    if (rst) begin
      link.monitorOut <= 1'b0;
      link.monitorOeN <= 1'b1;
    end else if (clkEn) begin
      link.monitorOeN <= 1'b0;
      case (monSel) // R2
        MON_OFF: begin
          link.monitorOut <= 1'b0;
          link.monitorOeN <= 1'b1;
        end
        MON_DIG_LOCK: link.monitorOut <= lockDetect;
        MON_FB_DIV:   link.monitorOut <= fbDivOut;
        MON_HIGH:     link.monitorOut <= 1'b1;
        MON_REF_DIV:  link.monitorOut <= refDivOut;
        MON_ANA_LOCK: begin
          // Pulls low only while the pump fires, which is brief once locked
          link.monitorOut <= 1'b0;
          link.monitorOeN <= ~(pumpActive & ~next_powerDown); // R6
        end
        MON_SDATA:    link.monitorOut <= sdataLevel;
        MON_LOW:      link.monitorOut <= 1'b0;
        default:      link.monitorOut <= 1'b0;
      endcase
    end
  end
endmodule

// ==== src/pll_serial_host.sv ====
/*
  Host controller: software writes a 24-bit word, the block shifts it out
  MSB first on a divided serial clock and pulses the load strobe.
  Assumes a plain register port with read data one cycle after the strobe.
*/
`timescale 1ns/1ps
module pll_serial_host #(
  parameter int HALF_CYC = pll_ctl_pkg::SCLK_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             irq,
  serial_link_if.host      link
);
  import pll_ctl_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_LOW   = 4'b0010,
    H_HIGH  = 4'b0100,
    H_LOAD  = 4'b1000
  } host_state_e;

  host_state_e          state;
  logic [LATCH_W-1:0]   word;
  logic [LATCH_W-1:0]   shifter;
  logic [4:0]           bitsLeft;
  logic [7:0]           timer;
  logic [IRQ_W-1:0]     irqStatus;
  logic [IRQ_W-1:0]     irqMask;
  logic [IRQ_W-1:0]     irqSet;
  logic                 monLevel;
  logic                 monLevelD;
  logic                 doneEvt;
  logic                 start;
  logic [LATCH_W-1:0]   cleanWord;

  initial begin
    if (HALF_CYC < 1 || HALF_CYC > 255) $error("pll_serial_host: HALF_CYC out of range");
  end

  // Reserved bits of reference and counter words forced to zero; reference word gets the only legal backlash width
  function automatic logic [LATCH_W-1:0] sanitize(input logic [LATCH_W-1:0] w);
    logic [LATCH_W-1:0] s;
    s = w;
    if (w[1:0] == SEL_REF) begin
      s = w & REF_KEEP_MASK; // R11
      s[BACKLASH_MSB:BACKLASH_LSB] = BACKLASH_REQ; // R1
    end else if (w[1:0] == SEL_FB) begin
      s = w & FB_KEEP_MASK; // R12
    end
    return s;
  endfunction

  assign start = wr && addr == OFF_WORD && state == H_IDLE;
  assign cleanWord = sanitize(wdata[LATCH_W-1:0]);

  // ****************************************
  // Monitor pin sampling
  // ****************************************
  pin_sync #(.WIDTH(1), .IDLE_LEVEL(1'b1)) monSync (
    .clk   (clk),
    .rst   (rst),
    .clkEn (clkEn),
    .pinIn (link.monitorLevel),
    .level (monLevel),
    .rise  ()
  );

  always_ff @(posedge clk) begin
    if (rst) monLevelD <= 1'b0;
    else if (clkEn) monLevelD <= monLevel;
  end

  // ****************************************
  // Shift sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state           <= H_IDLE;
      shifter         <= LATCH_RESET;
      word            <= LATCH_RESET;
      bitsLeft        <= 5'h0;
      timer           <= 8'h0;
      doneEvt         <= 1'b0;
      link.sclk       <= 1'b0;
      link.sdata      <= 1'b0;
      link.loadStrobe <= 1'b0;
    end else if (clkEn) begin
      doneEvt <= 1'b0;
      case (state)
        H_IDLE: begin
          if (start) begin
            word       <= cleanWord;
            shifter    <= cleanWord << 1;
            link.sdata <= cleanWord[LATCH_W-1]; // R7
            bitsLeft   <= 5'(LATCH_W);
            timer      <= 8'(HALF_CYC);
            state      <= H_LOW;
          end
        end
        H_LOW: begin
          if (timer == 8'h1) begin
            link.sclk <= 1'b1;
            timer     <= 8'(HALF_CYC);
            state     <= H_HIGH;
          end else timer <= timer - 8'h1;
        end
        H_HIGH: begin
          if (timer == 8'h1) begin
            link.sclk <= 1'b0;
            timer     <= 8'(HALF_CYC);
            bitsLeft  <= bitsLeft - 5'h1;
            if (bitsLeft == 5'h1) begin
              link.loadStrobe <= 1'b1; // R8
              state           <= H_LOAD;
            end else begin
              link.sdata <= shifter[LATCH_W-1]; // R7
              shifter    <= shifter << 1;
              state      <= H_LOW;
            end
          end else timer <= timer - 8'h1;
        end
        H_LOAD: begin
          if (timer == 8'h1) begin
            link.loadStrobe <= 1'b0;
            doneEvt         <= 1'b1;
            state           <= H_IDLE;
          end else timer <= timer - 8'h1;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // ****************************************
  // Registers and interrupt
  // ****************************************
  assign irqSet = {monLevelD & ~monLevel, monLevel & ~monLevelD, doneEvt};

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus <= '0;
      irqMask   <= '0;
      irq       <= 1'b0;
    end else if (clkEn) begin
      // A new event wins over a clear in the same cycle
      if (wr && addr == OFF_IRQ_STATUS) irqStatus <= (irqStatus & ~wdata[IRQ_W-1:0]) | irqSet;
      else irqStatus <= irqStatus | irqSet;
      if (wr && addr == OFF_IRQ_MASK) irqMask <= wdata[IRQ_W-1:0];
      irq <= |(irqStatus & irqMask);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) rdata <= 32'h0;
    else if (clkEn) begin
      if (!rd) rdata <= 32'h0;
      else if (addr == OFF_WORD) rdata <= {8'h0, word};
      else if (addr == OFF_STATUS) rdata <= {30'h0, monLevel, state != H_IDLE};
      else if (addr == OFF_IRQ_STATUS) rdata <= {29'h0, irqStatus};
      else if (addr == OFF_IRQ_MASK) rdata <= {29'h0, irqMask};
      else rdata <= 32'h0;
    end
  end
endmodule

// ==== src/serial_link_if.sv ====
/*
  Three-wire programming link plus the monitor pin.
  Assumes a pull-up on the monitor wire; the device drives it high or low while its enable is low.
*/
`timescale 1ns/1ps
interface serial_link_if;
  logic sclk;
  logic sdata;
  logic loadStrobe;
  logic monitorOut;
  logic monitorOeN;
  logic monitorLevel;

  // Pull-up wins whenever the device releases the pin
  assign monitorLevel = monitorOeN ? 1'b1 : monitorOut;

  modport host (
    output sclk,
    output sdata,
    output loadStrobe,
    input  monitorLevel
  );
  modport device (
    input  sclk,
    input  sdata,
    input  loadStrobe,
    output monitorOut,
    output monitorOeN
  );
endinterface
